// >>> src/power_control_pkg.sv
// constants for the power control register block
package power_control_pkg;
	// register indices; byte address is four times the index
	localparam logic [11:0] power_control_idx = 12'h087;
	localparam logic [11:0] event_status_idx = 12'h088;
	localparam logic [11:0] event_mask_idx = 12'h089;
	localparam logic [11:0] block_state_idx = 12'h08a;
	localparam logic [11:0] power_control_addr = 12'h21c;
	localparam logic [11:0] event_status_addr = 12'h220;
	localparam logic [11:0] event_mask_addr = 12'h224;
	localparam logic [11:0] block_state_addr = 12'h228;
	// power_control field positions
	localparam int baud_double_bit = 7;
	localparam int frame_error_bit = 6;
	localparam int brownout_pd_bit = 5;
	localparam int brownout_irq_bit = 4;
	localparam int user_flag_one_bit = 3;
	localparam int user_flag_zero_bit = 2;
	localparam logic [7:0] power_control_reset = 8'h00;
	// power reduction field codes
	localparam logic [1:0] pmode_normal = 2'h0;
	localparam logic [1:0] pmode_idle = 2'h1;
	localparam logic [1:0] pmode_down = 2'h2;
	localparam logic [1:0] pmode_total = 2'h3;
	// event bits
	localparam int ev_brownout = 0;
	localparam int ev_abort = 1;
	localparam int ev_wake = 2;
	localparam int ev_width = 3;
	// oscillator settle times, in cpu clocks
	localparam int settle_crystal_clocks = 1024;
	localparam int settle_other_clocks = 256;
	localparam logic [10:0] settle_crystal_cycles = 11'(settle_crystal_clocks);
	localparam logic [10:0] settle_other_cycles = 11'(settle_other_clocks);
	typedef enum logic [1:0] {
		st_normal = 2'b00,
		st_idle = 2'b01,
		st_down = 2'b10,
		st_settle = 2'b11
	} power_state_t;
endpackage

// >>> src/power_control_register.sv
// power control register with apb access, power mode sequencer and brownout routing
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module power_control_register
	import power_control_pkg::*;
(
	input wire logic clk_in, // cpu clock, 10 MHz
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb access phase
	input wire logic pwrite_in, // apb direction
	input wire logic [11:0] paddr_in, // apb byte address
	input wire logic [31:0] pwdata_in, // apb write data
	output logic [31:0] prdata_out, // apb read data
	output logic pready_out, // apb ready
	output logic pslverr_out, // apb error on unmapped address
	input wire logic timer1_overflow_in, // timer 1 overflow pulse
	output logic baud_tick_out, // baud source pulse to the serial port
	input wire logic serial_mode_bit_zero_in, // serial mode bit value
	input wire logic framing_error_flag_in, // serial framing error flag
	output logic serial_bit7_out, // what serial control bit 7 reads
	output logic frame_error_select_out, // selects receive flag location
	input wire logic brownout_in, // brownout detector level, asynchronous
	output logic brownout_enable_out, // brownout detector powered
	output logic brownout_irq_out, // brownout interrupt pulse
	output logic brownout_reset_out, // brownout reset request pulse
	input wire logic prog_erase_req_in, // program or erase request pulse
	output logic prog_erase_go_out, // request accepted pulse
	output logic prog_erase_abort_out, // request aborted pulse
	input wire logic wake_irq_in, // any enabled interrupt pending
	input wire logic clk_src_crystal_in, // oscillator is a crystal
	output logic cpu_run_out, // cpu executes
	output logic periph_run_out, // peripheral clocks run
	output logic osc_enable_out, // oscillator enabled
	output logic comparator_enable_out, // voltage comparators allowed
	output logic irq_out // level interrupt
);
	import power_control_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0] power_control, next_power_control;
	logic [ev_width-1:0] event_status, next_event_status;
	logic [ev_width-1:0] event_mask, next_event_mask;
	logic [ev_width-1:0] read_taken, next_read_taken;
	power_state_t state, next_state;
	logic total_down, next_total_down;
	logic [10:0] settle_count, next_settle_count;
	logic baud_phase, next_baud_phase;
	logic next_baud_tick;
	logic bo_meta, bo_sync, bo_prev;
	logic next_bo_irq, next_bo_reset, next_go, next_abort;
	logic [31:0] next_prdata;
	logic next_slverr;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic addr_known(input logic [11:0] a);
		addr_known = (a == power_control_addr) || (a == event_status_addr) ||
			(a == event_mask_addr) || (a == block_state_addr);
	endfunction

	logic setup_phase, wr_access, rd_access;
	logic bo_enabled, bo_event;
	assign setup_phase = psel_in && !penable_in;
	assign wr_access = psel_in && penable_in && pwrite_in;
	assign rd_access = psel_in && penable_in && !pwrite_in;
	// detector off by software or by total power down
	assign bo_enabled = !power_control[brownout_pd_bit] && !(state == st_down && total_down);
	assign bo_event = bo_enabled && bo_sync && !bo_prev;

	// ----------------------------------------
	// next values
	// ----------------------------------------
	always_comb
	begin
		next_power_control = power_control;
		next_event_mask = event_mask;
		next_state = state;
		next_total_down = total_down;
		next_settle_count = settle_count;
		next_baud_phase = baud_phase;
		next_baud_tick = 1'b0;
		next_bo_irq = 1'b0;
		next_bo_reset = 1'b0;
		next_go = 1'b0;
		next_abort = 1'b0;
		next_read_taken = read_taken;
		next_prdata = prdata_out;
		next_slverr = 1'b0;
		// baud source
		if (timer1_overflow_in)
		begin
			next_baud_phase = !baud_phase;
			next_baud_tick = power_control[baud_double_bit] || baud_phase;
		end
		// brownout routing
		if (bo_event)
		begin
			next_bo_irq = power_control[brownout_irq_bit];
			next_bo_reset = !power_control[brownout_irq_bit];
		end
		// flash command gate
		if (prog_erase_req_in)
		begin
			next_go = !power_control[brownout_pd_bit];
			next_abort = power_control[brownout_pd_bit];
		end
		// register writes; user flags are plain storage
		if (wr_access && paddr_in == power_control_addr)
			next_power_control = pwdata_in[7:0];
		if (wr_access && paddr_in == event_mask_addr)
			next_event_mask = pwdata_in[ev_width-1:0];
		// read data captured in setup, so status clears only what was seen
		if (setup_phase)
		begin
			next_slverr = !addr_known(paddr_in);
			next_read_taken = '0;
			case (paddr_in)
				power_control_addr: next_prdata = {24'h000000, power_control};
				event_status_addr:
				begin
					next_prdata = {29'h00000000, event_status};
					next_read_taken = pwrite_in ? '0 : event_status;
				end
				event_mask_addr: next_prdata = {29'h00000000, event_mask};
				block_state_addr: next_prdata = {20'h00000, settle_count[9:0], state};
				default: next_prdata = 32'h00000000;
			endcase
		end
		else if (penable_in)
			next_slverr = pslverr_out;
		// power mode sequencer
		case (state)
			st_normal:
			begin
				// a write of 00 stays here
				if (wr_access && paddr_in == power_control_addr)
				begin
					if (pwdata_in[1:0] == pmode_idle)
						next_state = st_idle;
					else if (pwdata_in[1:0] == pmode_down || pwdata_in[1:0] == pmode_total)
					begin
						next_state = st_down;
						next_total_down = pwdata_in[1:0] == pmode_total;
					end
				end
			end
			st_idle:
			begin
				if (wake_irq_in)
				begin
					next_state = st_normal;
					next_power_control[1:0] = pmode_normal;
				end
			end
			st_down:
			begin
				// brownout is not a wake source in total power down
				if (wake_irq_in || (bo_event && power_control[brownout_irq_bit]))
				begin
					next_state = st_settle;
					next_settle_count = clk_src_crystal_in ?
						settle_crystal_cycles : settle_other_cycles;
				end
			end
			st_settle:
			begin
				next_settle_count = settle_count - 11'h001;
				if (settle_count == 11'h001)
				begin
					next_state = st_normal;
					next_total_down = 1'b0;
					next_power_control[1:0] = pmode_normal;
				end
			end
			default: next_state = st_normal;
		endcase
	end

	// status: set wins over a read clear
	always_comb
	begin
		next_event_status = event_status;
		if (rd_access && paddr_in == event_status_addr)
			next_event_status = event_status & ~read_taken;
		next_event_status[ev_brownout] = next_event_status[ev_brownout] | bo_event;
		next_event_status[ev_abort] = next_event_status[ev_abort] |
			(prog_erase_req_in && power_control[brownout_pd_bit]);
		next_event_status[ev_wake] = next_event_status[ev_wake] |
			(state == st_settle && settle_count == 11'h001);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (!rst_n_in)
		begin
			power_control <= power_control_reset;
			event_status <= '0;
			event_mask <= '0;
			read_taken <= '0;
			state <= st_normal;
			total_down <= 1'b0;
			settle_count <= 11'h000;
			baud_phase <= 1'b0;
			baud_tick_out <= 1'b0;
			bo_meta <= 1'b0;
			bo_sync <= 1'b0;
			bo_prev <= 1'b0;
			brownout_irq_out <= 1'b0;
			brownout_reset_out <= 1'b0;
			prog_erase_go_out <= 1'b0;
			prog_erase_abort_out <= 1'b0;
			prdata_out <= 32'h00000000;
			pslverr_out <= 1'b0;
		end
		else
		begin
			power_control <= next_power_control;
			event_status <= next_event_status;
			event_mask <= next_event_mask;
			read_taken <= next_read_taken;
			state <= next_state;
			total_down <= next_total_down;
			settle_count <= next_settle_count;
			baud_phase <= next_baud_phase;
			baud_tick_out <= next_baud_tick;
			bo_meta <= brownout_in;
			bo_sync <= bo_meta;
			bo_prev <= bo_sync;
			brownout_irq_out <= next_bo_irq;
			brownout_reset_out <= next_bo_reset;
			prog_erase_go_out <= next_go;
			prog_erase_abort_out <= next_abort;
			prdata_out <= next_prdata;
			pslverr_out <= next_slverr;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign pready_out = 1'b1;
	assign serial_bit7_out = power_control[frame_error_bit] ?
		framing_error_flag_in : serial_mode_bit_zero_in;
	assign frame_error_select_out = power_control[frame_error_bit];
	assign brownout_enable_out = bo_enabled;
	assign cpu_run_out = state == st_normal;
	assign periph_run_out = state == st_normal || state == st_idle;
	assign osc_enable_out = state != st_down;
	assign comparator_enable_out = !(state == st_down && total_down);
	assign irq_out = |(event_status & event_mask);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_baud_double: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		timer1_overflow_in && power_control[baud_double_bit] |=> baud_tick_out)
		else $error("doubled baud tick missing");
	a_baud_halved: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		timer1_overflow_in && !power_control[baud_double_bit] && !baud_phase |=> !baud_tick_out)
		else $error("undivided baud tick");
	a_bit7_select: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		serial_bit7_out == (power_control[frame_error_bit] ?
			framing_error_flag_in : serial_mode_bit_zero_in))
		else $error("serial bit 7 wrong source");
	a_brownout_off: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		power_control[brownout_pd_bit] |-> !brownout_enable_out)
		else $error("brownout enabled while powered down");
	a_flash_gate: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		prog_erase_req_in |=> (prog_erase_abort_out == $past(power_control[brownout_pd_bit]))
			&& (prog_erase_go_out != prog_erase_abort_out))
		else $error("flash command gate wrong");
	a_user_flags: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_access && paddr_in == power_control_addr |=>
			power_control[3:2] == $past(pwdata_in[3:2]))
		else $error("user flags not stored");
	a_bo_route: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		bo_event && !power_control[brownout_irq_bit] |=> brownout_reset_out && !brownout_irq_out)
		else $error("brownout routed to wrong target");
	a_idle_exit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state == st_idle && wake_irq_in |=> cpu_run_out && power_control[1:0] == pmode_normal)
		else $error("idle not ended by interrupt");
	a_settle_len: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state == st_down && wake_irq_in && !clk_src_crystal_in |=>
			!cpu_run_out [*8] ##249 cpu_run_out)
		else $error("settle delay not 256 clocks");
	a_total_nobo: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		state == st_down && total_down |-> !brownout_enable_out && !comparator_enable_out)
		else $error("detector alive in total power down");
	c_idle_wake: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		state == st_idle ##1 state == st_normal);
	c_down_wake: cover property (@(posedge clk_in) disable iff (!rst_n_in)
		state == st_settle ##1 state == st_normal);
	c_abort: cover property (@(posedge clk_in) disable iff (!rst_n_in) prog_erase_abort_out);
endmodule
`default_nettype wire

// >>> tb/power_control_register_bench.sv
// self-checking bench for the power control register block
`timescale 1ns/1ps
`default_nettype none
module power_control_register_bench;
	import power_control_pkg::*;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
	logic pready_out, pslverr_out, last_err;
	logic timer1_overflow_in = 1'b0, serial_mode_bit_zero_in = 1'b0, framing_error_flag_in = 1'b1;
	logic brownout_in = 1'b0, prog_erase_req_in = 1'b0, wake_irq_in = 1'b0;
	logic clk_src_crystal_in = 1'b0;
	logic baud_tick_out, serial_bit7_out, frame_error_select_out, brownout_enable_out;
	logic brownout_irq_out, brownout_reset_out, prog_erase_go_out, prog_erase_abort_out;
	logic cpu_run_out, periph_run_out, osc_enable_out, comparator_enable_out, irq_out;
	int error_cnt = 0, num_checks = 0, ticks = 0, gos = 0, aborts = 0, birqs = 0, brsts = 0, n;

	power_control_register dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .timer1_overflow_in(timer1_overflow_in),
		.baud_tick_out(baud_tick_out), .serial_mode_bit_zero_in(serial_mode_bit_zero_in),
		.framing_error_flag_in(framing_error_flag_in), .serial_bit7_out(serial_bit7_out),
		.frame_error_select_out(frame_error_select_out), .brownout_in(brownout_in),
		.brownout_enable_out(brownout_enable_out), .brownout_irq_out(brownout_irq_out),
		.brownout_reset_out(brownout_reset_out), .prog_erase_req_in(prog_erase_req_in),
		.prog_erase_go_out(prog_erase_go_out), .prog_erase_abort_out(prog_erase_abort_out),
		.wake_irq_in(wake_irq_in), .clk_src_crystal_in(clk_src_crystal_in),
		.cpu_run_out(cpu_run_out), .periph_run_out(periph_run_out),
		.osc_enable_out(osc_enable_out), .comparator_enable_out(comparator_enable_out),
		.irq_out(irq_out));

	initial
	begin
		forever #50 clk_in = ~clk_in;
	end
	// pulse counters, so one-cycle outputs are never missed
	always @(posedge clk_in)
	begin
		ticks += (baud_tick_out === 1'b1);
		gos += (prog_erase_go_out === 1'b1);
		aborts += (prog_erase_abort_out === 1'b1);
		birqs += (brownout_irq_out === 1'b1);
		brsts += (brownout_reset_out === 1'b1);
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (i == 16)
		begin
			error_cnt++;
			report_and_stop();
		end
		rd = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic pulse_wake(input int bound);
		@(posedge clk_in);
		wake_irq_in <= 1'b1;
		@(posedge clk_in);
		wake_irq_in <= 1'b0;
		for (n = 0; n < bound && cpu_run_out !== 1'b1; n++)
			@(posedge clk_in);
		if (cpu_run_out !== 1'b1)
		begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic flash_req();
		@(posedge clk_in);
		prog_erase_req_in <= 1'b1;
		@(posedge clk_in);
		prog_erase_req_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	initial
	begin
		repeat (100000) @(posedge clk_in);
		error_cnt++;
		report_and_stop();
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rd_check(power_control_addr, 32'h0);
		check({cpu_run_out, periph_run_out, irq_out}, 32'h6);
		apb(1'b1, power_control_addr, 32'h0c);
		rd_check(power_control_addr, 32'h0c);
		check({cpu_run_out, brownout_enable_out, osc_enable_out}, 32'h7);
		$display("test reset and user flags done");
		for (int b = 0; b < 2; b++)
		begin
			apb(1'b1, power_control_addr, {24'h0, b[0], 7'h0});
			ticks = 0;
			repeat (4)
			begin
				@(posedge clk_in);
				timer1_overflow_in <= 1'b1;
				@(posedge clk_in);
				timer1_overflow_in <= 1'b0;
			end
			repeat (3) @(posedge clk_in);
			check(ticks, b ? 32'd4 : 32'd2);
			apb(1'b1, power_control_addr, {24'h0, 1'b0, b[0], 6'h0});
			@(posedge clk_in);
			check({frame_error_select_out, serial_bit7_out}, {30'h0, b[0], b[0]});
			serial_mode_bit_zero_in <= 1'b1;
			framing_error_flag_in <= 1'b0;
			@(posedge clk_in);
			check({frame_error_select_out, serial_bit7_out}, {30'h0, b[0], ~b[0]});
			serial_mode_bit_zero_in <= 1'b0;
			framing_error_flag_in <= 1'b1;
		end
		$display("test baud and frame select done");
		apb(1'b1, event_mask_addr, 32'h2);
		apb(1'b1, power_control_addr, 32'h20);
		@(posedge clk_in);
		check(brownout_enable_out, 32'h0);
		rd_check(event_status_addr, 32'h0);
		gos = 0;
		aborts = 0;
		flash_req();
		check({gos[3:0], aborts[3:0]}, 32'h01);
		check(irq_out, 32'h1);
		rd_check(event_status_addr, 32'h2);
		@(posedge clk_in);
		check(irq_out, 32'h0);
		apb(1'b1, power_control_addr, 32'h0);
		flash_req();
		check({gos[3:0], aborts[3:0]}, 32'h11);
		check({brownout_enable_out, irq_out}, 32'h2);
		$display("test brownout gate and flash done");
		for (int s = 0; s < 2; s++)
		begin
			apb(1'b1, power_control_addr, {27'h0, s[0], 4'h0});
			birqs = 0;
			brsts = 0;
			@(posedge clk_in);
			brownout_in <= 1'b1;
			repeat (8) @(posedge clk_in);
			brownout_in <= 1'b0;
			repeat (8) @(posedge clk_in);
			check({birqs[3:0], brsts[3:0]}, s ? 32'h10 : 32'h01);
		end
		rd_check(event_status_addr, 32'h1);
		$display("test brownout select done");
		apb(1'b1, power_control_addr, 32'h1);
		@(posedge clk_in);
		check({cpu_run_out, periph_run_out, osc_enable_out}, 32'h3);
		pulse_wake(20);
		check(cpu_run_out, 32'h1);
		rd_check(power_control_addr, 32'h0);
		for (int k = 0; k < 2; k++)
		begin
			clk_src_crystal_in <= k[0];
			apb(1'b1, power_control_addr, 32'h2);
			@(posedge clk_in);
			check({cpu_run_out, periph_run_out, osc_enable_out}, 32'h0);
			rd_check(block_state_addr, 32'h2);
			pulse_wake(1200);
			check(n >= (k ? 1023 : 255) && n <= (k ? 1026 : 258), 32'h1);
			rd_check(power_control_addr, 32'h0);
			rd_check(event_status_addr, 32'h4);
		end
		$display("test idle and power down done");
		apb(1'b1, power_control_addr, 32'h13);
		@(posedge clk_in);
		check({brownout_enable_out, comparator_enable_out, cpu_run_out}, 32'h0);
		birqs = 0;
		brownout_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		brownout_in <= 1'b0;
		check({birqs[3:0], 3'h0, cpu_run_out}, 32'h0);
		clk_src_crystal_in <= 1'b0;
		pulse_wake(300);
		check({cpu_run_out, comparator_enable_out, brownout_enable_out}, 32'h7);
		$display("test total power down done");
		apb(1'b1, 12'h300, 32'hff);
		check(last_err, 32'h1);
		rd_check(12'h300, 32'h0);
		check(last_err, 32'h1);
		rd_check(power_control_addr, 32'h10);
		check(last_err, 32'h0);
		$display("test unmapped access done");
		report_and_stop();
	end
endmodule
`default_nettype wire
